/* File: rtl/ind_pkg.sv */
// constants, field layouts and carrier types for the indirect register access window
// Contract
// RULE1: select field chooses pattern, link, or die-ID page
// RULE2: auto-step adds one after each data access
// RULE3: prefetch on: offset write issues page read strobe
// RULE4: prefetch plus step: strobe after each data read
// RULE5: software sets prefetch only for prefetching pages
// RULE6: eight-bit offset register, resets to zero
// RULE7: data write forwarded; data read returns page byte
// RULE8: software writes control, then offset, then data
// RULE9: auto-step reaches successive offsets without rewriting offset
// RULE10: control upper bits read zero; fields reset zero
package ind_pkg;

  // ********************************************************
  // bus shape
  // ********************************************************
  localparam int ADDR_W = 12; // byte address width on the register bus
  localparam int DATA_W = 32; // bus data width

  // ********************************************************
  // register indices and byte addresses (byte address is four times the index)
  // ********************************************************
  localparam logic [7:0] CTRL_IDX = 8'hB0; // indirect_control
  localparam logic [7:0] OFFS_IDX = 8'hB1; // indirect_offset
  localparam logic [7:0] DATA_IDX = 8'hB2; // indirect_data_port
  localparam logic [ADDR_W-1:0] CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] OFFS_ADDR = {2'h0, OFFS_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] DATA_ADDR = {2'h0, DATA_IDX, 2'h0};

  // ********************************************************
  // control register fields and reset values
  // ********************************************************
  localparam int PREFETCH_BIT = 0; // read_prefetch_enable
  localparam int STEP_BIT = 1; // auto_step_enable
  localparam int SEL_LSB = 2; // target_page_select low bit
  localparam int SEL_MSB = 4; // target_page_select high bit
  localparam logic [7:0] CTRL_WMASK = 8'h1F; // upper three bits are read-only zero
  localparam logic [7:0] CTRL_RST = 8'h00; // page 0, no step, no prefetch
  localparam logic [7:0] OFFS_RST = 8'h00; // offset after reset
  localparam logic [7:0] OFFS_STEP = 8'h01; // auto-step increment

  // ********************************************************
  // page codes and bus responses
  // ********************************************************
  typedef enum logic [2:0] {
    PAGE_PATTERN_GEN = 3'b000,
    PAGE_LINK_TX = 3'b001,
    PAGE_DIE_ID = 3'b010
  } page_t;
  localparam logic [1:0] RESP_OKAY = 2'h0; // normal answer
  localparam logic [1:0] RESP_SLVERR = 2'h2; // answer to an unmapped address

  // ********************************************************
  // carrier towards the internal pages
  // ********************************************************
  typedef struct packed {
    logic [2:0] sel; // selected page code
    logic [7:0] addr; // current offset, also address of a read strobe
    logic rd; // one-cycle read strobe
    logic wr; // one-cycle write strobe
    logic [7:0] waddr; // offset of the write strobe
    logic [7:0] wdata; // byte of the write strobe
  } page_req_t;

  // ********************************************************
  // whole state of the block
  // ********************************************************
  typedef struct packed {
    logic [7:0] ctrl; // indirect_control
    logic [7:0] offs; // indirect_offset
    logic aw_have; // write address held
    logic [ADDR_W-1:0] awaddr; // held write address
    logic w_have; // write data held
    logic [7:0] wbyte; // held low data byte
    logic wlane; // held strobe of byte lane 0
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [DATA_W-1:0] rdata;
    page_req_t req; // page side outputs
  } state_t;
  localparam state_t STATE_RST = '0; // every field, control included, clears

endpackage

/* File: rtl/indirect_register_access.sv */
// AXI4-Lite window giving indirect byte access to internal register pages
`timescale 1ns/100ps
module indirect_register_access (
  // clock, reset and freeze
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // write address channel
  input wire logic awvalid,
  output logic awready,
  input wire logic [ind_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // write data channel
  input wire logic wvalid,
  output logic wready,
  input wire logic [ind_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  // write response channel
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // read address channel
  input wire logic arvalid,
  output logic arready,
  input wire logic [ind_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // read data channel
  output logic rvalid,
  input wire logic rready,
  output logic [ind_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  // internal page side
  output ind_pkg::page_req_t page_req,
  input wire logic [7:0] page_rdata
);

  // ********************************************************
  // state and decode
  // ********************************************************
  ind_pkg::state_t s_r; // registered state
  ind_pkg::state_t s_nxt; // next state
  logic wr_go; // both halves of a write are held
  logic wr_ctrl; // write to the control register
  logic wr_offs; // write to the offset register
  logic wr_data; // write to the data port
  logic rd_go; // read address taken this cycle
  logic rd_data; // read of the data port
  logic rd_ctrl; // read of the control register
  logic step_on; // auto-step enabled
  logic pref_on; // read prefetch enabled

  // protection bits carry no meaning for this block
  logic prot_unused;
  assign prot_unused = ^{awprot, arprot, wdata[31:8], wstrb[3:1]};

  // write executes one cycle after its second half is taken
  assign wr_go = s_r.aw_have && s_r.w_have;
  // a write with lane 0 off is answered but changes nothing
  assign wr_ctrl = wr_go && s_r.wlane && (s_r.awaddr == ind_pkg::CTRL_ADDR);
  assign wr_offs = wr_go && s_r.wlane && (s_r.awaddr == ind_pkg::OFFS_ADDR);
  assign wr_data = wr_go && s_r.wlane && (s_r.awaddr == ind_pkg::DATA_ADDR);
  assign rd_go = arvalid && s_r.arready;
  assign rd_ctrl = rd_go && (araddr == ind_pkg::CTRL_ADDR);
  assign rd_data = rd_go && (araddr == ind_pkg::DATA_ADDR);
  assign step_on = s_r.ctrl[ind_pkg::STEP_BIT];
  assign pref_on = s_r.ctrl[ind_pkg::PREFETCH_BIT];

  // ********************************************************
  // next state
  // ********************************************************
  always_comb begin
    s_nxt = s_r;
    // strobes last one cycle
    s_nxt.req.rd = 1'b0;
    s_nxt.req.wr = 1'b0;
    // take the write halves in either order
    if (awvalid && s_r.awready) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.awaddr = awaddr;
    end
    if (wvalid && s_r.wready) begin
      s_nxt.w_have = 1'b1;
      s_nxt.wbyte = wdata[7:0];
      s_nxt.wlane = wstrb[0];
    end
    // answers leave when taken
    if (bready && s_r.bvalid) begin
      s_nxt.bvalid = 1'b0;
    end
    if (rready && s_r.rvalid) begin
      s_nxt.rvalid = 1'b0;
    end
    // execute a held write
    if (wr_go) begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = ind_pkg::RESP_OKAY;
      if (!((s_r.awaddr == ind_pkg::CTRL_ADDR) || (s_r.awaddr == ind_pkg::OFFS_ADDR) ||
            (s_r.awaddr == ind_pkg::DATA_ADDR))) begin
        s_nxt.bresp = ind_pkg::RESP_SLVERR;
      end
    end
    // RULE10: upper control bits stay zero
    if (wr_ctrl) begin
      s_nxt.ctrl = s_r.wbyte & ind_pkg::CTRL_WMASK;
    end
    // RULE6: offset register takes the byte
    if (wr_offs) begin
      s_nxt.offs = s_r.wbyte;
      // RULE3: prefetch strobe on offset write
      if (pref_on) begin
        s_nxt.req.rd = 1'b1;
      end
    end
    // RULE7: forward data byte to the page
    if (wr_data) begin
      s_nxt.req.wr = 1'b1;
      s_nxt.req.waddr = s_r.offs;
      s_nxt.req.wdata = s_r.wbyte;
      // RULE2: step after the write
      if (step_on) begin
        s_nxt.offs = s_nxt.offs + ind_pkg::OFFS_STEP;
      end
    end
    // reads answer one cycle after the address is taken
    if (rd_go) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = ind_pkg::RESP_OKAY;
      unique case (araddr)
        // RULE10: reserved bits read zero
        ind_pkg::CTRL_ADDR: begin
          s_nxt.rdata = {24'h000000, s_r.ctrl};
        end
        ind_pkg::OFFS_ADDR: begin
          s_nxt.rdata = {24'h000000, s_r.offs};
        end
        ind_pkg::DATA_ADDR: begin
          // RULE7: byte the page shows at the current offset
          s_nxt.rdata = {24'h000000, page_rdata};
          // RULE9: step so the next read reaches the next offset
          if (step_on) begin
            s_nxt.offs = s_nxt.offs + ind_pkg::OFFS_STEP;
            // RULE4: refetch at the new offset
            if (pref_on) begin
              s_nxt.req.rd = 1'b1;
            end
          end
        end
        default: begin
          // unmapped address answers an error and reads zero
          s_nxt.rdata = 32'h00000000;
          s_nxt.rresp = ind_pkg::RESP_SLVERR;
        end
      endcase
    end
    // RULE1: page select follows the control field
    s_nxt.req.sel = s_nxt.ctrl[ind_pkg::SEL_MSB:ind_pkg::SEL_LSB];
    // pages look at the offset the register holds, so reads never see a stale address
    s_nxt.req.addr = s_nxt.offs;
    // one write and one read at a time: refuse new halves while one is pending
    s_nxt.awready = !s_nxt.aw_have && !s_nxt.bvalid;
    s_nxt.wready = !s_nxt.w_have && !s_nxt.bvalid;
    s_nxt.arready = !s_nxt.rvalid;
  end

  // ********************************************************
  // state register
  // ********************************************************
  // ce low freezes everything, bus handshakes included
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= ind_pkg::STATE_RST;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign awready = s_r.awready;
  assign wready = s_r.wready;
  assign bvalid = s_r.bvalid;
  assign bresp = s_r.bresp;
  assign arready = s_r.arready;
  assign rvalid = s_r.rvalid;
  assign rdata = s_r.rdata;
  assign rresp = s_r.rresp;
  assign page_req = s_r.req;

  // ********************************************************
  // checks
  // ********************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // RULE1: select output follows control write
  sel_follow_a: assert property (ce && wr_ctrl |=> page_req.sel == $past(s_r.wbyte[4:2])) // RULE1
    else $error("page select does not follow control write");

  // RULE2: offset steps by one after data write
  step_write_a: assert property (ce && wr_data && step_on && !rd_data |=> // RULE2
    s_r.offs == $past(s_r.offs) + 8'h01)
    else $error("offset did not step after data write");

  // RULE3: offset write with prefetch strobes new offset
  prefetch_offs_a: assert property (ce && wr_offs && pref_on && !(rd_data && step_on) |=> // RULE3
    page_req.rd && page_req.addr == $past(s_r.wbyte))
    else $error("no read strobe after offset write");

  // RULE4: data read with both bits strobes next offset
  prefetch_read_a: assert property (ce && rd_data && step_on && pref_on && !wr_offs && // RULE4
    !wr_data |=> page_req.rd && page_req.addr == $past(s_r.offs) + 8'h01)
    else $error("no read strobe after stepping data read");

  // RULE6: offset register holds the written byte
  offs_store_a: assert property (ce && wr_offs && !rd_data |=> // RULE6
    s_r.offs == $past(s_r.wbyte) && bvalid)
    else $error("offset register did not take written byte");

  // RULE7: data write forwarded with old offset
  data_fwd_a: assert property (ce && wr_data |=> page_req.wr && // RULE7
    page_req.waddr == $past(s_r.offs) && page_req.wdata == $past(s_r.wbyte))
    else $error("data write not forwarded");

  // RULE7: data read returns page byte
  data_ret_a: assert property (ce && rd_data |=> // RULE7
    rvalid && rdata == {24'h000000, $past(page_rdata)})
    else $error("data read did not return page byte");

  // RULE9: without step the offset stays put
  no_step_a: assert property (ce && (wr_data || rd_data) && !step_on && !wr_offs |=> // RULE9
    $stable(s_r.offs))
    else $error("offset moved with auto-step off");

  // RULE10: control reads show zero upper bits
  ctrl_zero_a: assert property (ce && rd_ctrl |=> rdata[31:5] == 27'h0000000) // RULE10
    else $error("control upper bits not zero");

  // write answer comes one cycle after execution
  bresp_time_a: assert property (ce && wr_go |=> bvalid)
    else $error("write answer missing");

  step_write_c: cover property (ce && wr_data && step_on ##[1:8] ce && wr_data);
  prefetch_read_c: cover property (ce && rd_data && step_on && pref_on);
  unmapped_c: cover property (ce && rd_go ##1 rresp == ind_pkg::RESP_SLVERR);
  die_page_c: cover property (page_req.sel == ind_pkg::PAGE_DIE_ID && page_req.wr);

endmodule

/* File: tb/indirect_register_access_test.sv */
// self-checking bench for the indirect register access window
`timescale 1ns/100ps
module indirect_register_access_test;
  // ****************************************
  // signals
  // ****************************************
  logic clk, rst, ce, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [ind_pkg::ADDR_W-1:0] awaddr, araddr;
  logic [ind_pkg::DATA_W-1:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  ind_pkg::page_req_t page_req;
  logic [7:0] page_rdata; // answer of the page model
  logic [7:0] ctl, off; // bench copy of control and offset
  logic [31:0] seed = 32'hD744; // xorshift state
  int n_errors, total_checks;
  logic [33:0] rq[$]; // expected read answers, response over data
  logic [1:0] bq[$]; // expected write responses
  logic [15:0] wq[$]; // expected page writes, offset over byte
  logic [7:0] sq[$]; // expected read strobe offsets

  indirect_register_access DUT (.clk(clk), .rst(rst), .ce(ce), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(4'h1), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .page_req(page_req),
    .page_rdata(page_rdata));

  // ****************************************
  // helpers
  // ****************************************
  // page content depends on page code and offset, so a wrong page shows up
  function automatic logic [7:0] pg(input logic [2:0] s, input logic [7:0] a);
    return {s, 5'h00} ^ a ^ 8'h5A;
  endfunction
  assign page_rdata = pg(page_req.sel, page_req.addr);

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    if (n_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ****************************************
  // bus master tasks
  // ****************************************
  // upper data bits are random: only the low byte may matter
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    bq.push_back(r);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'(rnd()), d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      // an edge with ce low takes nothing, so keep offering
      if (awready === 1'b1 && ce) awvalid <= 1'b0;
      if (wready === 1'b1 && ce) wvalid <= 1'b0;
    end while (!(bvalid === 1'b1 && ce));
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    rq.push_back(e);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready === 1'b1 && ce) arvalid <= 1'b0;
    end while (!(rvalid === 1'b1 && ce));
    rready <= 1'b0;
  endtask

  task automatic set_ctl(input logic [7:0] v);
    wr(ind_pkg::CTRL_ADDR, v, ind_pkg::RESP_OKAY);
    ctl = v & 8'h1F;
  endtask

  // a prefetching control setting expects a strobe at the new offset
  task automatic set_off(input logic [7:0] v);
    if (ctl[0]) sq.push_back(v);
    off = v;
    wr(ind_pkg::OFFS_ADDR, v, ind_pkg::RESP_OKAY);
  endtask

  // expectations are queued before the bus cycle, ahead of the answer
  task automatic rd_data();
    logic [7:0] e;
    e = pg(ctl[4:2], off);
    if (ctl[1]) begin
      off++;
      if (ctl[0]) sq.push_back(off);
    end
    rd(ind_pkg::DATA_ADDR, {26'h0, e});
  endtask

  task automatic wr_data(input logic [7:0] d);
    wq.push_back({off, d});
    if (ctl[1]) off++;
    wr(ind_pkg::DATA_ADDR, d, ind_pkg::RESP_OKAY);
  endtask

  // ****************************************
  // monitor: oldest note against each result
  // ****************************************
  always @(posedge clk) begin
    // a frozen block consumes nothing, so only ce-high edges count
    if (!rst && ce) begin
      if (rvalid && rready) begin
        cmp({rresp, rdata}, rq.size() ? rq.pop_front() : 'x);
      end
      if (bvalid && bready) begin
        cmp(34'(bresp), 34'(bq.size() ? bq.pop_front() : 'x));
      end
      if (page_req.wr) begin
        cmp(34'({page_req.waddr, page_req.wdata}), 34'(wq.size() ? wq.pop_front() : 'x));
      end
      if (page_req.rd) begin
        cmp(34'(page_req.addr), 34'(sq.size() ? sq.pop_front() : 'x));
      end
    end
  end

  // ****************************************
  // clock, watchdog and main sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // about 150 bus cycles are needed; this leaves wide margin
  initial begin
    #(5000 * 100);
    n_errors++;
    conclude();
  end

  initial begin
    {rst, ce, awvalid, wvalid, bready, arvalid, rready} = 7'h60;
    {awaddr, araddr, wdata} = '0;
    ctl = 8'h00;
    off = 8'h00;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(ind_pkg::CTRL_ADDR, 34'h0);
    rd(ind_pkg::OFFS_ADDR, 34'h0);
    set_ctl(8'hFF);
    rd(ind_pkg::CTRL_ADDR, 34'h1F);
    // control, then offset, then data, for every page code with auto-step on
    // prefetch only on the page that wants its data fetched ahead
    for (int s = 0; s < 3; s++) begin
      set_ctl({3'h0, 3'(s), 1'b1, s == 1});
      set_off(8'(rnd()));
      repeat (3) rd_data();
      repeat (2) wr_data(8'(rnd()));
      rd(ind_pkg::OFFS_ADDR, {26'h0, off});
    end
    // stepping past the top offset wraps to zero
    set_off(8'hFF);
    rd_data();
    rd(ind_pkg::OFFS_ADDR, {26'h0, off});
    // no step, prefetch on: one strobe on the offset write, none after the read
    set_ctl(8'h09);
    set_off(8'h10);
    rd_data();
    wr_data(8'hC3);
    // ce low freezes the block: the offered read waits until ce returns
    ce <= 1'b0;
    fork
      rd(ind_pkg::OFFS_ADDR, {26'h0, off});
      begin
        repeat (5) begin
          @(posedge clk);
          cmp(34'(rvalid), 34'h0);
        end
        ce <= 1'b1;
      end
    join
    // unmapped places answer with an error and change nothing
    rd(12'h000, {2'h2, 32'h0});
    wr(12'h004, 8'h55, ind_pkg::RESP_SLVERR);
    rd(ind_pkg::OFFS_ADDR, {26'h0, off});
    repeat (3) @(posedge clk);
    cmp(34'(rq.size() + bq.size() + wq.size() + sq.size()), 34'h0);
    conclude();
  end
endmodule
